/* kwd_pkg.sv */
// Constants for the keyed watchdog timer: register map, field layout,
// reset values, key codes and timing counts.
// Assumes a single 20 MHz system clock and 32-bit AHB-Lite register access.
package kwd_pkg;

  // Register byte addresses
  localparam logic [7:0] KWD_ADDR_WDT_CTRL  = 8'h00;
  localparam logic [7:0] KWD_ADDR_SYS_FLAGS = 8'h04;
  localparam logic [7:0] KWD_ADDR_STATUS    = 8'h08;

  // Watchdog control fields
  localparam int unsigned KWD_KEY_MSB = 7;
  localparam int unsigned KWD_KEY_LSB = 3;
  localparam int unsigned KWD_SEL_MSB = 2;
  localparam logic [7:0]  KWD_WDT_CTRL_POR = 8'h53;
  localparam logic [4:0]  KWD_KEY_ENABLE   = 5'h0A;
  localparam logic [4:0]  KWD_KEY_DISABLE  = 5'h15;

  // System control flag fields
  localparam int unsigned KWD_SCF_SYSCLK_BIT = 7;
  localparam int unsigned KWD_SCF_KEYRST_BIT = 0;

  // Status register fields
  localparam int unsigned KWD_ST_PDOWN_BIT = 0;
  localparam int unsigned KWD_ST_OVF_BIT   = 1;
  localparam int unsigned KWD_ST_EN_BIT    = 2;

  // Counter and timing
  localparam int unsigned KWD_CNT_W           = 18;
  localparam int unsigned KWD_SYS_PERIOD_NS   = 50;
  localparam logic [1:0]  KWD_KEY_RST_TICKS   = 2'h2;

  // Key reset sequencer states
  typedef enum logic [1:0] {
    KWD_KS_IDLE = 2'b01,
    KWD_KS_WAIT = 2'b10
  } kwd_key_state_t;

endpackage : kwd_pkg

/* kwd_sync_edge.sv */
// Two-flop synchroniser with a rising-edge tick for a slow pin clock.
// Assumes the pin toggles much slower than the system clock.
`timescale 1ns/100ps
`default_nettype none
module kwd_sync_edge (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out
);

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  // Only sync_q reads meta_q; edge detect looks at later stages
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;

endmodule : kwd_sync_edge
`default_nettype wire

/* kwd_watchdog.sv */
// Keyed watchdog timer top: AHB-Lite register slave, sub clock counter,
// key check with delayed reset, time-out and power-down flags.
// Assumes CPU instruction strobes are one-cycle pulses on clk_sys_in and the
// oscillator pins are asynchronous slow clocks.
// How it works
// - time-out after 2^N sub clock ticks
// - key 01010B enables, 10101B disables watchdog
// - other key: reset after 1-2 RC cycles
// - key flag set by hardware, software only clears
// - power-up: key enable, period select 011
// - normal time-out: device reset, overflow flag set
// - sleep time-out: flag, clear PC and SP only
// - key reset, clear or halt clears counter
// - flag register bits 6..3 read zero
// - sub clock from RC or crystal oscillator
// - sleep time-out leaves both flags at one
// - power-down flag: clear instruction clears, halt sets
`timescale 1ns/100ps
`default_nettype none
module kwd_watchdog
  import kwd_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Oscillator pins and source select
  input  wire logic        low_speed_rc_osc_in,
  input  wire logic        low_speed_crystal_osc_in,
  input  wire logic        sub_src_crystal_in,
  // CPU side
  input  wire logic        clear_watchdog_instruction_in,
  input  wire logic        halt_instruction_in,
  input  wire logic        sleep_idle_in,
  output logic             device_reset_out,
  output logic             pc_sp_clear_out,
  output logic             overflow_flag_out,
  output logic             powerdown_flag_out,
  output logic             idle_sysclk_keep_out
);

  // Last count value before time-out for a period select code
  function automatic logic [KWD_CNT_W-1:0] period_last(input logic [2:0] sel);
    logic [4:0] n;
    n = 5'h08;
    unique case (sel)
      3'h0: n = 5'h08;
      3'h1: n = 5'h0A;
      3'h2: n = 5'h0C;
      3'h3: n = 5'h0E;
      3'h4: n = 5'h0F;
      3'h5: n = 5'h10;
      3'h6: n = 5'h11;
      3'h7: n = 5'h12;
    endcase
    period_last = KWD_CNT_W'((19'h00001 << n) - 19'h00001);
  endfunction : period_last

  // Decode of one register byte address against a bus address
  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] reg_addr);
    addr_hit = (a[31:8] == 24'h000000) && (a[7:0] == reg_addr);
  endfunction : addr_hit

  logic rc_level;
  logic rc_tick;
  logic xt_tick;
  logic src_xt;

  // Both oscillators synchronised; select pin too, as it is a strap
  kwd_sync_edge u_sync_rc (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .pin_in     (low_speed_rc_osc_in),
    .level_out  (rc_level),
    .rise_out   (rc_tick)
  );
  kwd_sync_edge u_sync_xt (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .pin_in     (low_speed_crystal_osc_in),
    .level_out  (),
    .rise_out   (xt_tick)
  );
  kwd_sync_edge u_sync_sel (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .pin_in     (sub_src_crystal_in),
    .level_out  (src_xt),
    .rise_out   ()
  );

  logic sub_tick;
  assign sub_tick = src_xt ? xt_tick : rc_tick;

  // Bus state
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic [7:0]  wr_addr_q;
  logic [7:0]  wr_addr_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic        hready_q;

  // Core state
  logic [7:0]           ctrl_q;
  logic [7:0]           ctrl_d;
  logic                 keyrst_flag_q;
  logic                 keyrst_flag_d;
  logic                 sysclk_keep_q;
  logic                 sysclk_keep_d;
  logic                 ovf_flag_q;
  logic                 ovf_flag_d;
  logic                 pdown_flag_q;
  logic                 pdown_flag_d;
  logic [KWD_CNT_W-1:0] cnt_q;
  logic [KWD_CNT_W-1:0] cnt_d;
  kwd_key_state_t       kstate_q;
  kwd_key_state_t       kstate_d;
  logic [1:0]           ktick_q;
  logic [1:0]           ktick_d;
  logic                 dev_rst_q;
  logic                 dev_rst_d;
  logic                 pcsp_q;
  logic                 pcsp_d;

  logic       addr_phase;
  logic       wr_ctrl;
  logic       wr_flags;
  logic [4:0] key;
  logic       key_en;
  logic       key_bad;
  logic       key_fire;
  logic       timeout;

  assign addr_phase = hsel_in & hready_in & htrans_in[1];
  assign wr_ctrl    = wr_pend_q & (wr_addr_q == KWD_ADDR_WDT_CTRL);
  assign wr_flags   = wr_pend_q & (wr_addr_q == KWD_ADDR_SYS_FLAGS);
  assign key        = ctrl_q[KWD_KEY_MSB:KWD_KEY_LSB];
  assign key_en     = (key == KWD_KEY_ENABLE);
  assign key_bad    = !key_en && (key != KWD_KEY_DISABLE);
  assign key_fire   = (kstate_q == KWD_KS_WAIT) && rc_tick &&
                      (ktick_q == KWD_KEY_RST_TICKS - 2'h1);
  // Greater-or-equal so a shorter period cuts a long count at the next sub clock tick
  assign timeout    = key_en && sub_tick &&
                      (cnt_q >= period_last(ctrl_q[KWD_SEL_MSB:0]));

  // Key reset sequencer: counts RC edges, so 1 to 2 RC cycles elapse
  always_comb begin
    kstate_d = kstate_q;
    ktick_d  = ktick_q;
    unique case (kstate_q)
      KWD_KS_IDLE: begin
        ktick_d = 2'h0;
        if (key_bad) begin
          kstate_d = KWD_KS_WAIT;
        end
      end
      KWD_KS_WAIT: begin
        if (key_fire) begin
          kstate_d = KWD_KS_IDLE;
          ktick_d  = 2'h0;
        end else if (rc_tick) begin
          ktick_d = ktick_q + 2'h1;
        end
      end
      default: begin
        kstate_d = KWD_KS_IDLE;
        ktick_d  = 2'h0;
      end
    endcase
  end

  // Control register, counter, flags and reset strobes
  always_comb begin
    ctrl_d        = ctrl_q;
    sysclk_keep_d = sysclk_keep_q;
    keyrst_flag_d = keyrst_flag_q;
    ovf_flag_d    = ovf_flag_q;
    pdown_flag_d  = pdown_flag_q;
    cnt_d         = cnt_q;
    dev_rst_d     = 1'b0;
    pcsp_d        = 1'b0;
    if (wr_ctrl) begin
      ctrl_d = hwdata_in[7:0];
    end
    if (wr_flags) begin
      sysclk_keep_d = hwdata_in[KWD_SCF_SYSCLK_BIT];
      // Software may clear the key flag but never set it
      if (!hwdata_in[KWD_SCF_KEYRST_BIT]) begin
        keyrst_flag_d = 1'b0;
      end
    end
    // Counter: runs only while enabled, cleared by instruction or halt
    if (!key_en || clear_watchdog_instruction_in || halt_instruction_in) begin
      cnt_d = '0;
    end else if (timeout) begin
      cnt_d = '0;
    end else if (sub_tick) begin
      cnt_d = cnt_q + KWD_CNT_W'(1);
    end
    // Clear instruction wipes both flags; halt sets power-down
    if (clear_watchdog_instruction_in) begin
      pdown_flag_d = 1'b0;
      ovf_flag_d   = 1'b0;
    end
    if (halt_instruction_in) begin
      pdown_flag_d = 1'b1;
      ovf_flag_d   = 1'b0;
    end
    // Time-out: set wins over any clear in the same cycle
    if (timeout) begin
      ovf_flag_d = 1'b1;
      if (sleep_idle_in) begin
        pcsp_d = 1'b1;
      end else begin
        dev_rst_d = 1'b1;
      end
    end
    // Key reset restores the control value, else it would fire forever
    if (key_fire) begin
      dev_rst_d     = 1'b1;
      keyrst_flag_d = 1'b1;
      ctrl_d        = KWD_WDT_CTRL_POR;
      cnt_d         = '0;
    end
  end

  // Bus next state; read data taken from next values, so a write in the
  // preceding data phase is already visible
  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    hrdata_d  = hrdata_q;
    if (addr_phase) begin
      wr_pend_d = hwrite_in;
      wr_addr_d = haddr_in[7:0];
      hrdata_d  = 32'h00000000;
      if (!hwrite_in) begin
        if (addr_hit(haddr_in, KWD_ADDR_WDT_CTRL)) begin
          hrdata_d[7:0] = ctrl_d;
        end else if (addr_hit(haddr_in, KWD_ADDR_SYS_FLAGS)) begin
          hrdata_d[KWD_SCF_SYSCLK_BIT] = sysclk_keep_d;
          hrdata_d[KWD_SCF_KEYRST_BIT] = keyrst_flag_d;
        end else if (addr_hit(haddr_in, KWD_ADDR_STATUS)) begin
          hrdata_d[KWD_ST_PDOWN_BIT] = pdown_flag_d;
          hrdata_d[KWD_ST_OVF_BIT]   = ovf_flag_d;
          hrdata_d[KWD_ST_EN_BIT]    = (ctrl_d[KWD_KEY_MSB:KWD_KEY_LSB] == KWD_KEY_ENABLE);
        end
      end
    end
    if (addr_phase && hwrite_in && !(addr_hit(haddr_in, KWD_ADDR_WDT_CTRL) ||
        addr_hit(haddr_in, KWD_ADDR_SYS_FLAGS))) begin
      wr_pend_d = 1'b0;                                                     // Unmapped write ignored
    end
  end

  // Registers; power-up values of the control word and flags
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q        <= KWD_WDT_CTRL_POR;
      sysclk_keep_q <= 1'b0;
      keyrst_flag_q <= 1'b0;
      ovf_flag_q    <= 1'b0;
      pdown_flag_q  <= 1'b0;
      cnt_q         <= '0;
      kstate_q      <= KWD_KS_IDLE;
      ktick_q       <= 2'h0;
      dev_rst_q     <= 1'b0;
      pcsp_q        <= 1'b0;
      wr_pend_q     <= 1'b0;
      wr_addr_q     <= 8'h00;
      hrdata_q      <= 32'h00000000;
      hready_q      <= 1'b0;
    end else begin
      ctrl_q        <= ctrl_d;
      sysclk_keep_q <= sysclk_keep_d;
      keyrst_flag_q <= keyrst_flag_d;
      ovf_flag_q    <= ovf_flag_d;
      pdown_flag_q  <= pdown_flag_d;
      cnt_q         <= cnt_d;
      kstate_q      <= kstate_d;
      ktick_q       <= ktick_d;
      dev_rst_q     <= dev_rst_d;
      pcsp_q        <= pcsp_d;
      wr_pend_q     <= wr_pend_d;
      wr_addr_q     <= wr_addr_d;
      hrdata_q      <= hrdata_d;
      hready_q      <= 1'b1;                                                // Zero wait states
    end
  end

  // Outputs come from flip-flops, except hresp_out which is tied low
  assign hrdata_out           = hrdata_q;
  assign hreadyout_out        = hready_q;
  assign hresp_out            = 1'b0;
  assign device_reset_out     = dev_rst_q;
  assign pc_sp_clear_out      = pcsp_q;
  assign overflow_flag_out    = ovf_flag_q;
  assign powerdown_flag_out   = pdown_flag_q;
  assign idle_sysclk_keep_out = sysclk_keep_q;

  logic unused_bits;
  assign unused_bits = rc_level ^ ^hsize_in ^ htrans_in[0] ^ ^hwdata_in[31:8];

endmodule : kwd_watchdog
`default_nettype wire

/* kwd_watchdog_props.sv */
// Port-level checks for the keyed watchdog timer, bound into every instance.
// Assumes clear and halt strobes never meet a time-out tick in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module kwd_watchdog_props (
  input wire logic        clk_sys_in,
  input wire logic        nrst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        clear_watchdog_instruction_in,
  input wire logic        halt_instruction_in,
  input wire logic        sleep_idle_in,
  input wire logic        device_reset_out,
  input wire logic        pc_sp_clear_out,
  input wire logic        overflow_flag_out,
  input wire logic        powerdown_flag_out
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  // A time-out picks one kind of reset, never both
  pulse_excl_a: assert property (!(device_reset_out && pc_sp_clear_out))
    else $error("device reset and pc/sp clear together");
  rst_single_a: assert property (device_reset_out |=> !device_reset_out)
    else $error("device reset longer than one cycle");
  pcsp_sleep_a: assert property (pc_sp_clear_out |-> $past(sleep_idle_in) && overflow_flag_out)
    else $error("pc/sp clear outside sleep or without flag");
  ovf_cause_a: assert property ($rose(overflow_flag_out) |-> device_reset_out || pc_sp_clear_out)
    else $error("overflow flag set without a time-out");
  ovf_sticky_a: assert property (overflow_flag_out && !clear_watchdog_instruction_in
    && !halt_instruction_in |=> overflow_flag_out)
    else $error("overflow flag dropped by itself");
  pd_cause_a: assert property ($rose(powerdown_flag_out) |-> $past(halt_instruction_in))
    else $error("power-down flag set without halt");
  halt_flags_a: assert property (halt_instruction_in |=> powerdown_flag_out && !overflow_flag_out)
    else $error("halt did not update flags");
  clear_quiet_a: assert property (clear_watchdog_instruction_in && !halt_instruction_in
    |=> (!powerdown_flag_out && !overflow_flag_out) [*8])
    else $error("flags not clear after clear instruction");
  // Reserved bits of the flag register must read back as zero
  rsvd_zero_a: assert property (hsel_in && hready_in && htrans_in[1] && !hwrite_in
    && haddr_in == 32'h4 |=> hrdata_out[6:3] == 4'h0)
    else $error("reserved flag bits not zero");
endmodule : kwd_watchdog_props

bind kwd_watchdog kwd_watchdog_props kwd_watchdog_props_inst (.clk_sys_in, .nrst_in,
  .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
  .clear_watchdog_instruction_in, .halt_instruction_in, .sleep_idle_in,
  .device_reset_out, .pc_sp_clear_out, .overflow_flag_out, .powerdown_flag_out);
`default_nettype wire

/* kwd_watchdog_tb.sv */
// Self-checking bench for the keyed watchdog timer.
// Drives AHB-Lite, both oscillator pins and the CPU strobes; checker is bound.
`timescale 1ns/100ps
`default_nettype none
module kwd_watchdog_tb;
  import kwd_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        hsel_in    = 1'b0;
  logic [31:0] haddr_in   = 32'h0;
  logic [1:0]  htrans_in  = 2'h0;
  logic        hwrite_in  = 1'b0;
  logic [31:0] hwdata_in  = 32'h0;
  logic        rc_pin     = 1'b0;
  logic        xt_pin     = 1'b0;
  logic        src_xt     = 1'b0;
  logic        clr_in     = 1'b0;
  logic        halt_in    = 1'b0;
  logic        sleep_in   = 1'b0;
  wire  [31:0] hrdata;
  wire         hready, hresp, dev_rst, pcsp, ovf, pd, keep;
  logic [31:0] rd, v;
  logic [2:0]  pv;
  int          fail_count = 0;
  int          checks     = 0;
  int          n, cyc;

  kwd_watchdog kwd_watchdog_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .low_speed_rc_osc_in(rc_pin),
    .low_speed_crystal_osc_in(xt_pin), .sub_src_crystal_in(src_xt),
    .clear_watchdog_instruction_in(clr_in), .halt_instruction_in(halt_in),
    .sleep_idle_in(sleep_in), .device_reset_out(dev_rst), .pc_sp_clear_out(pcsp),
    .overflow_flag_out(ovf), .powerdown_flag_out(pd), .idle_sysclk_keep_out(keep));

  always #25 clk_sys_in = ~clk_sys_in;

  // RC pin period 8 clocks, crystal 6, so the source select shows in timing
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    rc_pin <= (cyc % 8) < 4;
    xt_pin <= (cyc % 6) < 3;
    if (cyc == 90000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic in_win(input int got, input int lo, input int hi);
    chk({31'h0, got >= lo && got <= hi}, 32'h1);
  endtask : in_win

  // Time-out length in clocks for a select code and a tick period
  function automatic int tmo(input logic [2:0] ps, input int per);
    int b;
    b = (ps < 3'h4) ? 8 + 2 * ps : 11 + ps;
    return (1 << b) * per;
  endfunction : tmo

  // Bounded wait for hready sampled high at a rising edge
  task automatic hold_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (hready !== 1'b1 && k < 20);
    // A slave that never answers counts as a mismatch
    if (hready !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask : hold_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    hold_ready();
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    hold_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic instr(input logic h);
    @(posedge clk_sys_in);
    clr_in <= ~h;
    halt_in <= h;
    @(posedge clk_sys_in);
    clr_in <= 1'b0;
    halt_in <= 1'b0;
  endtask : instr

  // Counts clocks to the next reset pulse, looked at mid-cycle where the
  // one-cycle pulse stands; n equals lim when none came
  task automatic wait_pulse(input int lim);
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (dev_rst !== 1'b1 && pcsp !== 1'b1 && n < lim);
    pv = {dev_rst, pcsp, ovf};
    @(posedge clk_sys_in);
  endtask : wait_pulse

  initial begin
    n = $urandom(32'h8f08);
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    bus(0, KWD_ADDR_WDT_CTRL, 0);
    chk(rd, {24'h0, KWD_KEY_ENABLE, 3'h3});
    bus(0, KWD_ADDR_SYS_FLAGS, 0);
    chk(rd, 32'h0);
    bus(0, KWD_ADDR_STATUS, 0);
    chk(rd, 32'h4);
    bus(0, 8'h0C, 0);
    chk(rd, 32'h0);
    for (int p = 0; p < 8; p++) begin
      bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_ENABLE, 3'(p)});
      bus(0, KWD_ADDR_WDT_CTRL, 0);
      chk(rd, {24'h0, KWD_KEY_ENABLE, 3'(p)});
    end
    v = $urandom | 32'h1;
    bus(1, KWD_ADDR_SYS_FLAGS, v);
    bus(0, KWD_ADDR_SYS_FLAGS, 0);
    chk(rd, {24'h0, v[7], 7'h0});
    chk(keep, v[7]);
    $display("test registers done");
    // RC source at select 000, crystal at select 001
    for (int s = 0; s < 2; s++) begin
      src_xt <= s[0];
      bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_ENABLE, 3'(s)});
      instr(0);
      repeat ($urandom_range(900, 100)) @(posedge clk_sys_in);
      instr(0);
      wait_pulse(20000);
      in_win(n, tmo(3'(s), s ? 6 : 8) - 12, tmo(3'(s), s ? 6 : 8) + 14);
      chk(pv, 3'b101);
      $display("test time-out %0d done", s);
    end
    src_xt <= 1'b0;
    bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_ENABLE, 3'h0});
    instr(1);
    sleep_in <= 1'b1;
    wait_pulse(20000);
    in_win(n, tmo(3'h0, 8) - 12, tmo(3'h0, 8) + 14);
    chk(pv[2:1], 2'b01);
    sleep_in <= 1'b0;
    bus(0, KWD_ADDR_STATUS, 0);
    chk(rd, 32'h7);
    instr(0);
    bus(0, KWD_ADDR_STATUS, 0);
    chk(rd, 32'h4);
    $display("test sleep done");
    bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_ENABLE, 3'h1});
    instr(0);
    repeat (2400) @(posedge clk_sys_in);
    bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_ENABLE, 3'h0});
    wait_pulse(60);
    in_win(n, 1, 20);
    chk(pv[2], 1'b1);
    $display("test period change done");
    bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_DISABLE, 3'h0});
    wait_pulse(3000);
    chk(n, 3000);
    bus(0, KWD_ADDR_STATUS, 0);
    chk(rd[2], 1'b0);
    bus(1, KWD_ADDR_WDT_CTRL, {24'h0, KWD_KEY_ENABLE, 3'h0});
    wait_pulse(3000);
    in_win(n, tmo(3'h0, 8) - 16, tmo(3'h0, 8) + 14);
    $display("test disable done");
    for (int i = 0; i < 3; i++) begin
      do v = $urandom;
      while (v[7:3] == KWD_KEY_ENABLE || v[7:3] == KWD_KEY_DISABLE);
      bus(1, KWD_ADDR_WDT_CTRL, v);
      wait_pulse(60);
      in_win(n, 8, 32);
      chk(pv[2:1], 2'b10);
      bus(0, KWD_ADDR_SYS_FLAGS, 0);
      chk(rd[0], 1'b1);
      bus(0, KWD_ADDR_WDT_CTRL, 0);
      chk(rd, {24'h0, KWD_KEY_ENABLE, 3'h3});
      bus(1, KWD_ADDR_SYS_FLAGS, 32'h0);
      bus(0, KWD_ADDR_SYS_FLAGS, 0);
      chk(rd[0], 1'b0);
    end
    $display("test key reset done");
    close_out();
  end
endmodule : kwd_watchdog_tb
`default_nettype wire
